// ---- include/axis_analog_output_consts.vh ----
// constants for the axis analog output stage
// assumes a 50 MHz core clock and an internal phase clock made from it
`ifndef AXIS_ANALOG_OUTPUT_CONSTS_VH
`define AXIS_ANALOG_OUTPUT_CONSTS_VH

// =====================================================================
// clock and phase timing
`define CLOCK_KHZ              50000
`define PHASE_KHZ_DEFAULT      20
`define PHASE_PERIOD_DEFAULT   (`CLOCK_KHZ / `PHASE_KHZ_DEFAULT)
`define PERIOD_W               16

// =====================================================================
// set value ranges
`define SMOOTH_MIN             16'hC000
`define SMOOTH_MAX             16'h3FFF
`define SMOOTH_OFFSET          15'h4000
`define SMOOTH_FRAC_BITS       15
`define CONV_OFFSET            16'h8000
`define MULT_W                 3

// =====================================================================
// effective level figure: levels = LEVEL_RATE_KHZ / f_pulse(kHz)
`define LEVEL_RATE_KHZ         300000
`define LEVEL_TICKS_PER_CLOCK  (`LEVEL_RATE_KHZ / `CLOCK_KHZ)

// =====================================================================
// direct-drive link defaults
`define AMP_CLK_DIV_RESET      3'h5
`define AMP_STROBE_RESET       24'hFFFFFC
`define AMP_DELAY_RESET        8'h00
`define AMP_HEADER_RESET       4'h2

// =====================================================================
// output method select
`define METHOD_SMOOTHED        1'b0
`define METHOD_CONVERTER       1'b1

`endif

// ---- rtl/pulse_channel.v ----
// one smoothed pulse-width channel
// assumes a phase tick pulse from the parent on the same clock
`timescale 1ns/1ns
`include "axis_analog_output_consts.vh"

module pulse_channel #(
  parameter PERIOD_W = `PERIOD_W
) (
  input  wire                  clock,
  input  wire                  rst_n,
  input  wire                  phase_tick,
  input  wire [PERIOD_W-1:0]   phase_period,
  input  wire [`MULT_W-1:0]    rate_mult,
  input  wire [15:0]           set_value,
  output reg                   pulse_out,
  output reg  [PERIOD_W+3:0]   duty_ticks
);

  // =====================================================================
  // period span is two phase periods; counter steps by mult+1
  wire [PERIOD_W:0]   span = {phase_period, 1'b0};
  wire [3:0]          step = {1'b0, rate_mult} + 4'h1;                      // [RULE3]
  reg  [PERIOD_W:0]   cnt_q;
  reg  [PERIOD_W:0]   thresh_q;
  wire [PERIOD_W+1:0] cnt_sum = {1'b0, cnt_q} + {{(PERIOD_W-2){1'b0}}, step};

  // =====================================================================
  // clamp to the smoothed range, then offset to unsigned
  wire signed [15:0] sv = set_value;
  wire [15:0] clamped = (sv < $signed(`SMOOTH_MIN)) ? `SMOOTH_MIN :
                        (sv > $signed(`SMOOTH_MAX)) ? `SMOOTH_MAX : set_value;   // [RULE1]
  wire [14:0] unsigned_sv = clamped[14:0] + `SMOOTH_OFFSET;
  wire [PERIOD_W+15:0] prod = unsigned_sv * span;                          // [RULE11]
  wire [PERIOD_W:0] thresh_d = prod[PERIOD_W+15:`SMOOTH_FRAC_BITS];

  // on-time threshold over the two-period span kept in 300 MHz-equivalent ticks
  // product kept at full width first, then cut to the port width on purpose
  wire [31:0]         level_full  = {{(31-PERIOD_W){1'b0}}, thresh_d} * `LEVEL_TICKS_PER_CLOCK; // [RULE4]
  wire [PERIOD_W+3:0] level_ticks = level_full[PERIOD_W+3:0];              // [RULE4]

  always @(posedge clock) begin
    if (!rst_n) begin
      cnt_q      <= {(PERIOD_W+1){1'b0}};
      thresh_q   <= {1'b0, phase_period};
      pulse_out  <= 1'b0;
      duty_ticks <= {(PERIOD_W+4){1'b0}};
    end else begin
      // restart at every phase tick; the rate stays exact for odd multipliers only, where the count lands on a span boundary
      if (phase_tick) begin
        cnt_q    <= {(PERIOD_W+1){1'b0}};
        thresh_q <= thresh_d;
        duty_ticks <= level_ticks;
      end else if (cnt_sum >= {1'b0, span}) begin
        cnt_q <= cnt_sum[PERIOD_W:0] - span;                               // [RULE2]
      end else begin
        cnt_q <= cnt_sum[PERIOD_W:0];
      end
      pulse_out <= (cnt_q < thresh_q);                                     // [RULE11]
    end
  end

endmodule // pulse_channel

// ---- rtl/axis_analog_output_pwm.v ----
// analog command output stage for the axis channels plus direct-drive link
// assumes one 50 MHz clock, config and set values from same-clock logic
`timescale 1ns/1ns
`include "axis_analog_output_consts.vh"

// How it works
// RULE1 - smoothed mode clamps the set value to -16384..16383 spanning full negative to full positive scale.
// RULE2 - the smoothed pulse rate is the phase clock rate times (multiplier plus one) over two; code meets it for odd multipliers only.
// RULE3 - the per-channel rate multiplier is a three-bit integer 0 to 7.
// RULE4 - smoothed effective levels equal 300000 over the pulse rate in kHz, reported as a tick count; code reports on-time threshold times 6.
// RULE5 - software should pick a smoothed pulse rate of 30 kHz or more for low ripple.
// RULE6 - converter mode takes a signed -32768..32767 set value mapped linearly to the output.
// RULE7 - converter mode gives every set value its own distinct output code.
// RULE8 - link settings reset to divider 5, strobe FFFFFC, delay 0 and header count 2.
// RULE9 - software keeps phase and pulse rates at 40 kHz or below when the link is used.
// RULE10 - the link sends current commands to the amplifier and reads measured current back.
// RULE11 - smoothed duty varies linearly with the set value, half duty at zero; the code meets this for odd multipliers only.
module axis_analog_output_pwm #(
  parameter CHANNELS = 2,
  parameter PERIOD_W = `PERIOD_W
) (
  input  wire                      CLOCK,
  input  wire                      RST_N,
  input  wire [PERIOD_W-1:0]       PHASE_PERIOD,
  input  wire [CHANNELS-1:0]       METHOD,
  input  wire [CHANNELS*3-1:0]     PULSE_RATE_MULTIPLIER,
  input  wire [CHANNELS*16-1:0]    SET_VALUE,
  input  wire                      LINK_CFG_WRITE,
  input  wire [2:0]                LINK_CLK_DIV_IN,
  input  wire [23:0]               LINK_STROBE_IN,
  input  wire [7:0]                LINK_DELAY_IN,
  input  wire [3:0]                LINK_HEADER_IN,
  input  wire [CHANNELS*16-1:0]    CURRENT_COMMAND,
  input  wire [CHANNELS*16-1:0]    AMP_CURRENT_FEEDBACK,
  output wire                      PHASE_TICK,
  output wire [CHANNELS-1:0]       SMOOTHED_PULSE_OUTPUT,
  output wire [CHANNELS*(PERIOD_W+4)-1:0] SMOOTHED_DUTY_TICKS,
  output reg  [CHANNELS*16-1:0]    CONVERTER_OUTPUT,
  output reg  [CHANNELS-1:0]       CONVERTER_LOAD,
  output reg  [2:0]                AMP_CONVERTER_CLOCK_DIVIDER,
  output reg  [23:0]               AMP_CONVERTER_STROBE_WORD,
  output reg  [7:0]                AMP_CONVERTER_SAMPLE_DELAY,
  output reg  [3:0]                AMP_CONVERTER_HEADER_COUNT,
  output reg  [CHANNELS*16-1:0]    LINK_CURRENT_COMMAND,
  output reg  [CHANNELS*16-1:0]    MEASURED_CURRENT
);

  // =====================================================================
  // internal phase clock divider
  reg  [PERIOD_W-1:0] phase_cnt_q;
  wire [PERIOD_W-1:0] period_safe = (PHASE_PERIOD == {PERIOD_W{1'b0}}) ?
                                    {{(PERIOD_W-1){1'b0}}, 1'b1} : PHASE_PERIOD;
  wire                phase_hit = (phase_cnt_q >= period_safe - {{(PERIOD_W-1){1'b0}}, 1'b1});

  always @(posedge CLOCK) begin
    if (!RST_N) begin
      phase_cnt_q <= {PERIOD_W{1'b0}};
    end else if (phase_hit) begin
      phase_cnt_q <= {PERIOD_W{1'b0}};
    end else begin
      phase_cnt_q <= phase_cnt_q + {{(PERIOD_W-1){1'b0}}, 1'b1};
    end
  end

  assign PHASE_TICK = phase_hit;

  // =====================================================================
  // feedback from the amplifier comes from off-chip: two flops first
  reg [CHANNELS*16-1:0] fb_meta_q;
  reg [CHANNELS*16-1:0] fb_sync_q;

  always @(posedge CLOCK) begin
    if (!RST_N) begin
      fb_meta_q <= {(CHANNELS*16){1'b0}};
      fb_sync_q <= {(CHANNELS*16){1'b0}};
    end else begin
      fb_meta_q <= AMP_CURRENT_FEEDBACK;
      fb_sync_q <= fb_meta_q;
    end
  end

  // =====================================================================
  // per-channel outputs
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : g_chan
      wire [15:0] sv = SET_VALUE[ch*16 +: 16];
      wire        pulse;

      pulse_channel #(
        .PERIOD_W(PERIOD_W)
      ) u_pulse (
        .clock       (CLOCK),
        .rst_n       (RST_N),
        .phase_tick  (phase_hit),
        .phase_period(period_safe),
        .rate_mult   (PULSE_RATE_MULTIPLIER[ch*3 +: 3]),                   // [RULE3]
        .set_value   (sv),
        .pulse_out   (pulse),
        .duty_ticks  (SMOOTHED_DUTY_TICKS[ch*(PERIOD_W+4) +: (PERIOD_W+4)])
      );

      // idle level of the smoothed pin in converter mode is low
      assign SMOOTHED_PULSE_OUTPUT[ch] = (METHOD[ch] == `METHOD_SMOOTHED) & pulse;

      always @(posedge CLOCK) begin
        if (!RST_N) begin
          CONVERTER_OUTPUT[ch*16 +: 16]     <= `CONV_OFFSET;
          CONVERTER_LOAD[ch]                <= 1'b0;
          LINK_CURRENT_COMMAND[ch*16 +: 16] <= 16'h0000;
          MEASURED_CURRENT[ch*16 +: 16]     <= 16'h0000;
        end else begin
          CONVERTER_LOAD[ch] <= phase_hit & (METHOD[ch] == `METHOD_CONVERTER);
          if (phase_hit) begin
            // offset binary keeps all 65536 codes distinct and monotonic
            if (METHOD[ch] == `METHOD_CONVERTER) begin
              CONVERTER_OUTPUT[ch*16 +: 16] <= sv ^ `CONV_OFFSET;           // [RULE6] [RULE7]
            end
            LINK_CURRENT_COMMAND[ch*16 +: 16] <= CURRENT_COMMAND[ch*16 +: 16]; // [RULE10]
            MEASURED_CURRENT[ch*16 +: 16]     <= fb_sync_q[ch*16 +: 16];      // [RULE10]
          end
        end
      end
    end
  endgenerate

  // =====================================================================
  // direct-drive link settings
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      AMP_CONVERTER_CLOCK_DIVIDER <= `AMP_CLK_DIV_RESET;                   // [RULE8]
      AMP_CONVERTER_STROBE_WORD   <= `AMP_STROBE_RESET;                    // [RULE8]
      AMP_CONVERTER_SAMPLE_DELAY  <= `AMP_DELAY_RESET;                     // [RULE8]
      AMP_CONVERTER_HEADER_COUNT  <= `AMP_HEADER_RESET;                    // [RULE8]
    end else if (LINK_CFG_WRITE) begin
      AMP_CONVERTER_CLOCK_DIVIDER <= LINK_CLK_DIV_IN;
      AMP_CONVERTER_STROBE_WORD   <= LINK_STROBE_IN;
      AMP_CONVERTER_SAMPLE_DELAY  <= LINK_DELAY_IN;
      AMP_CONVERTER_HEADER_COUNT  <= LINK_HEADER_IN;
    end
  end

endmodule // axis_analog_output_pwm

// ---- verif/axis_analog_output_pwm_assertions.sv ----
// port assertions for the analog output stage
// assumes two channels and a phase period held at 8 clocks
`timescale 1ns/1ns
module aop_checker #(
  parameter CHANNELS = 2
) (
  input wire                   CLOCK,
  input wire                   RST_N,
  input wire                   PHASE_TICK,
  input wire [CHANNELS-1:0]    METHOD,
  input wire [CHANNELS*16-1:0] SET_VALUE,
  input wire [CHANNELS*16-1:0] CURRENT_COMMAND,
  input wire                   LINK_CFG_WRITE,
  input wire [2:0]             LINK_CLK_DIV_IN,
  input wire [CHANNELS-1:0]    SMOOTHED_PULSE_OUTPUT,
  input wire [CHANNELS*16-1:0] CONVERTER_OUTPUT,
  input wire [CHANNELS-1:0]    CONVERTER_LOAD,
  input wire [2:0]             AMP_CONVERTER_CLOCK_DIVIDER,
  input wire [23:0]            AMP_CONVERTER_STROBE_WORD,
  input wire [3:0]             AMP_CONVERTER_HEADER_COUNT,
  input wire [CHANNELS*16-1:0] LINK_CURRENT_COMMAND
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // ==========================================
  // phase timebase and converter path
  sequence quiet_seven; !PHASE_TICK [*7]; endsequence
  sequence load_pulse; CONVERTER_LOAD[1] ##1 !CONVERTER_LOAD[1]; endsequence
  tick_spacing_a:
    assert property (PHASE_TICK |=> quiet_seven ##1 PHASE_TICK) else $error("phase tick spacing wrong");
  load_after_tick_a:
    assert property (PHASE_TICK && METHOD[1] |=> load_pulse) else $error("converter load not one cycle");
  conv_code_a:
    assert property (PHASE_TICK && METHOD[1] |=> CONVERTER_OUTPUT[31:16] == ($past(SET_VALUE[31:16]) ^ 16'h8000))
    else $error("converter code wrong");
  smooth_off_a:
    assert property (METHOD[1] |-> !SMOOTHED_PULSE_OUTPUT[1]) else $error("pulse active in converter mode");
  // ==========================================
  // link settings and current command
  link_load_a:
    assert property (LINK_CFG_WRITE |=> AMP_CONVERTER_CLOCK_DIVIDER == $past(LINK_CLK_DIV_IN))
    else $error("link divider not loaded");
  link_hold_a:
    assert property (!LINK_CFG_WRITE |=> $stable(AMP_CONVERTER_STROBE_WORD)) else $error("strobe word moved");
  reset_dflt_a:
    assert property ($rose(RST_N) |-> AMP_CONVERTER_HEADER_COUNT == 4'h2 && AMP_CONVERTER_STROBE_WORD == 24'hFFFFFC)
    else $error("link defaults wrong");
  cmd_pass_a:
    assert property (PHASE_TICK |=> LINK_CURRENT_COMMAND == $past(CURRENT_COMMAND)) else $error("command not sent");
endmodule // aop_checker

bind axis_analog_output_pwm aop_checker #(.CHANNELS(CHANNELS)) chk_u (.CLOCK(CLOCK), .RST_N(RST_N),
  .PHASE_TICK(PHASE_TICK), .METHOD(METHOD), .SET_VALUE(SET_VALUE), .CURRENT_COMMAND(CURRENT_COMMAND),
  .LINK_CFG_WRITE(LINK_CFG_WRITE), .LINK_CLK_DIV_IN(LINK_CLK_DIV_IN), .SMOOTHED_PULSE_OUTPUT(SMOOTHED_PULSE_OUTPUT),
  .CONVERTER_OUTPUT(CONVERTER_OUTPUT), .CONVERTER_LOAD(CONVERTER_LOAD),
  .AMP_CONVERTER_CLOCK_DIVIDER(AMP_CONVERTER_CLOCK_DIVIDER), .AMP_CONVERTER_STROBE_WORD(AMP_CONVERTER_STROBE_WORD),
  .AMP_CONVERTER_HEADER_COUNT(AMP_CONVERTER_HEADER_COUNT), .LINK_CURRENT_COMMAND(LINK_CURRENT_COMMAND));

// ---- verif/amp_model.sv ----
// servo amplifier stand-in on the direct-drive link
// assumes the stage clock; answers each current command with a reading
`timescale 1ns/1ns
module amp_model (
  input  wire        clock,
  input  wire [31:0] command,
  output reg  [31:0] feedback
);
  // inverted reading so a path that just copies the command shows up
  always @(posedge clock) begin
    feedback <= ~command;
  end
endmodule // amp_model

// ---- verif/axis_analog_output_pwm_bench.sv ----
// self-checking bench for the analog output stage
// assumes phase period 8, two channels, amp_model on the link
`timescale 1ns/1ns
module axis_analog_output_pwm_bench;
  reg         clock, rst_n, cfg_wr, p;
  reg  [1:0]  method;
  reg  [5:0]  mult;
  reg  [31:0] setv, cmd;
  wire        tick;
  wire [1:0]  pulse, load;
  wire [39:0] duty;
  wire [31:0] conv, lcmd, meas, fb;
  wire [2:0]  div;
  wire [23:0] strobe;
  wire [7:0]  dly;
  wire [3:0]  hdr;
  integer     err_total, compares, i, hi, ri;
  // scaled timebase: period 8 keeps pulse rate above the ripple floor
  axis_analog_output_pwm dut_u (.CLOCK(clock), .RST_N(rst_n), .PHASE_PERIOD(16'h0008), .METHOD(method),
    .PULSE_RATE_MULTIPLIER(mult), .SET_VALUE(setv), .LINK_CFG_WRITE(cfg_wr), .LINK_CLK_DIV_IN(3'h2),
    .LINK_STROBE_IN(24'h123456), .LINK_DELAY_IN(8'h7F), .LINK_HEADER_IN(4'hA), .CURRENT_COMMAND(cmd),
    .AMP_CURRENT_FEEDBACK(fb), .PHASE_TICK(tick), .SMOOTHED_PULSE_OUTPUT(pulse), .SMOOTHED_DUTY_TICKS(duty),
    .CONVERTER_OUTPUT(conv), .CONVERTER_LOAD(load), .AMP_CONVERTER_CLOCK_DIVIDER(div),
    .AMP_CONVERTER_STROBE_WORD(strobe), .AMP_CONVERTER_SAMPLE_DELAY(dly), .AMP_CONVERTER_HEADER_COUNT(hdr),
    .LINK_CURRENT_COMMAND(lcmd), .MEASURED_CURRENT(meas));
  amp_model amp_u (.clock(clock), .command(lcmd), .feedback(fb));
  // ==========================================
  // shared tasks
  task chk(input [39:0] got, input [39:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task ticks(input integer n);
    begin
      repeat (n) begin
        @(negedge clock);
        while (tick !== 1'b1) @(negedge clock);
      end
      @(negedge clock);
    end
  endtask
  // sixteen clocks cover two phase periods, so any rate pattern repeats whole
  task measure;
    begin
      hi = 0;
      ri = 0;
      p = pulse[0];
      for (i = 0; i < 16; i = i + 1) begin
        @(negedge clock);
        hi = hi + pulse[0];
        ri = ri + (pulse[0] & ~p);
        p = pulse[0];
      end
    end
  endtask
  task wrap_up;
    begin
      if (err_total == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // ==========================================
  // scenarios
  task link_cfg;
    begin
      chk({hdr, dly, strobe, div}, {4'h2, 8'h00, 24'hFFFFFC, 3'h5});
      cfg_wr = 1'b1;
      @(negedge clock);
      cfg_wr = 1'b0;
      chk({hdr, dly, strobe, div}, {4'hA, 8'h7F, 24'h123456, 3'h2});
      rst_n = 1'b0;
      @(negedge clock);
      rst_n = 1'b1;
      @(negedge clock);
      chk({hdr, dly, strobe, div}, {4'h2, 8'h00, 24'hFFFFFC, 3'h5});
    end
  endtask
  task conv_point(input [15:0] s);
    begin
      setv[31:16] = s;
      ticks(2);
      chk(load, 2'b10);
      chk(conv[31:16], s ^ 16'h8000);
      chk(pulse[1], 1'b0);
    end
  endtask
  task duty_point(input [15:0] s, input [19:0] t, input integer h);
    begin
      setv[15:0] = s;
      ticks(2);
      measure;
      chk(duty[19:0], t);
      chk(hi, h);
    end
  endtask
  task rate_point(input [2:0] m);
    begin
      mult = {m, m};
      ticks(2);
      measure;
      chk(ri, m + 1);
      chk(hi, 8);
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #100000;
    err_total = err_total + 1;
    wrap_up;
  end
  initial begin
    {rst_n, cfg_wr, method, mult, setv, cmd} = {1'b0, 1'b0, 2'b10, 6'h09, 32'h0, 32'h0};
    err_total = 0;
    compares = 0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    link_cfg;
    conv_point(16'h8000);
    conv_point(16'h0000);
    conv_point(16'h0001);
    conv_point(16'h7FFF);
    duty_point(16'hC000, 20'h0, 0);
    duty_point(16'h0000, 20'h30, 8);
    duty_point(16'h3FFF, 20'h5A, 16);
    duty_point(16'h7FFF, 20'h5A, 16);
    duty_point(16'h8000, 20'h0, 0);
    setv[15:0] = 16'h0000;
    rate_point(3'h1);
    rate_point(3'h3);
    rate_point(3'h7);
    cmd = 32'h80017FFE;
    ticks(1);
    chk(lcmd, cmd);
    ticks(2);
    chk(meas, {~cmd});
    wrap_up;
  end
endmodule // axis_analog_output_pwm_bench
